// ===== hw/circ_pos_consts.vh
// constants for the repetitive / circular position block
// assumes the register port uses the documented 7-bit word addresses
`ifndef CIRC_POS_CONSTS_VH
`define CIRC_POS_CONSTS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_GENERAL_CONF 7'h00
`define ADDR_REFERENCE_CONFIG_REG 7'h01
`define ADDR_RAMP_SELECT 7'h20
`define ADDR_ACTUAL_POSITION 7'h21
`define ADDR_TARGET_POSITION 7'h37
`define ADDR_CIRCULAR_RANGE 7'h36
`define ADDR_REV_FRACTION 7'h7c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_POSITIONING 2
`define BIT_ZERO_ON_ARRIVAL 0
`define BIT_WRAP_ENABLE 1
`define BIT_TURNS_AT_RANGE 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_WORD 32'h00000000

// ----------------------------------------------------------------
// timing: step rate from the core clock
// ----------------------------------------------------------------
`define STEP_TIME_NS 1000
`define CLK_PERIOD_NS 10
`define STEP_CYCLES (`STEP_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== hw/step_divider.v
// step-rate divider: one-cycle enable pulse every div_cycles clocks
// assumes a single core clock and an asynchronous active-low reset
`timescale 1ns/100ps

module step_divider #(
    parameter integer div_cycles = 100
) (
    input wire clk, // core clock
    input wire rst_b, // async reset, active low
    output reg step_en_ff // one-cycle step enable
);

    reg [15:0] cnt_ff;
    wire last_cnt;

    assign last_cnt = (cnt_ff == div_cycles[15:0] - 16'h0001);

    // free-running count; pulse on terminal value
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 16'h0000;
            step_en_ff <= 1'b0;
        end else begin
            step_en_ff <= last_cnt;
            if (last_cnt) begin
                cnt_ff <= 16'h0000;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end

endmodule // step_divider

// ===== hw/circ_pos_core.v
// repetitive positioning and circular wrap of the actual position
// assumes a simple synchronous word register port and one core clock
//
// Function
// - arrival ends ramp, no restart by default
// - zero_on_arrival clears actual position at target
// - restart after clear only for nonzero target
// - new target accepted during repetitive motion
// - position kept within minus span to span minus one
// - positive step from top loads minus span
// - negative step from bottom loads span minus one
// - circular positioning takes shorter path to target
// - rev_fraction register provided at 0x7c
// - rev_fraction is 1.31 unsigned fixed point
// - each wrap crossing completes one revolution
// - fraction added to accumulator per revolution
// - accumulator overflow holds position one step
// - integer bit plus fractional carry hold two
// - turn counter counts wraps up and down
// - turn counter zero while wrap disabled
`timescale 1ns/100ps
`include "circ_pos_consts.vh"

module circ_pos_core #(
    parameter integer step_cycles = `STEP_CYCLES
) (
    input wire clk, // core clock
    input wire rst_b, // async reset, active low
    input wire reg_wr, // register write strobe
    input wire reg_rd, // register read strobe
    input wire [6:0] reg_addr, // register word address
    input wire [31:0] reg_wdata, // register write data
    output reg [31:0] reg_rdata_ff, // register read data
    output reg step_ff, // step pulse to driver
    output reg dir_ff, // direction, 1 = positive
    output reg moving_ff, // ramp is running
    output reg arrived_ff // actual equals target
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    reg [31:0] actual_ff;
    reg [31:0] target_ff;
    reg [31:0] span_ff;
    reg [31:0] frac_ff;
    reg [30:0] acc_ff;
    reg [1:0] hold_ff;
    reg [31:0] turns_ff;
    reg [2:0] ramp_select_ff;
    reg zero_on_arrival_ff;
    reg wrap_enable_ff;
    reg turns_at_range_ff;
    reg run_ff;
    wire step_en;

    step_divider #(
        .div_cycles(step_cycles)
    ) u_div (
        .clk(clk),
        .rst_b(rst_b),
        .step_en_ff(step_en)
    );

    // ----------------------------------------------------------------
    // direction choice and wrap arithmetic
    // ----------------------------------------------------------------
    wire positioning = ramp_select_ff[`BIT_POSITIONING];
    wire circ_on = wrap_enable_ff && (span_ff != 32'h00000000);
    wire at_target = (actual_ff == target_ff);
    wire [31:0] top_pos = span_ff - 32'h00000001;
    wire [31:0] bot_pos = 32'h00000000 - span_ff;
    wire [31:0] fwd_dist = target_ff - actual_ff;
    wire [31:0] full_rev = {span_ff[30:0], 1'b0};
    wire fwd_neg = fwd_dist[31];
    wire [31:0] fwd_abs = fwd_neg ? (32'h00000000 - fwd_dist) : fwd_dist;
    // across the wrap the path is one revolution minus the direct one
    wire wrap_shorter = (fwd_abs > span_ff);
    // the direct way is positive when the target lies above; the wrap reverses it
    wire go_pos = circ_on ? (~fwd_neg ^ wrap_shorter) : ~fwd_neg;
    wire hit_top = circ_on && go_pos && (actual_ff == top_pos);
    wire hit_bot = circ_on && !go_pos && (actual_ff == bot_pos);
    wire crossing = hit_top || hit_bot;
    wire [31:0] acc_sum = {1'b0, acc_ff} + {1'b0, frac_ff[30:0]};
    // integer bit gives one hold, fractional carry one more
    wire [1:0] extra_holds = {1'b0, frac_ff[31]} + {1'b0, acc_sum[31]};

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            target_ff <= `RST_WORD;
            span_ff <= `RST_WORD;
            frac_ff <= `RST_WORD;
            ramp_select_ff <= 3'h0;
            zero_on_arrival_ff <= 1'b0;
            wrap_enable_ff <= 1'b0;
            turns_at_range_ff <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `ADDR_GENERAL_CONF: begin
                    turns_at_range_ff <= reg_wdata[`BIT_TURNS_AT_RANGE];
                end
                `ADDR_REFERENCE_CONFIG_REG: begin
                    zero_on_arrival_ff <= reg_wdata[`BIT_ZERO_ON_ARRIVAL];
                    wrap_enable_ff <= reg_wdata[`BIT_WRAP_ENABLE];
                end
                `ADDR_RAMP_SELECT: ramp_select_ff <= reg_wdata[2:0];
                `ADDR_TARGET_POSITION: target_ff <= reg_wdata;
                `ADDR_CIRCULAR_RANGE: span_ff <= reg_wdata;
                `ADDR_REV_FRACTION: frac_ff <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // position, run state, holds and turn count
    // ----------------------------------------------------------------
    // a software write of the actual position wins over stepping
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            actual_ff <= `RST_WORD;
            acc_ff <= 31'h00000000;
            hold_ff <= 2'h0;
            turns_ff <= `RST_WORD;
            run_ff <= 1'b0;
            step_ff <= 1'b0;
            dir_ff <= 1'b1;
            moving_ff <= 1'b0;
            arrived_ff <= 1'b0;
        end else begin
            step_ff <= 1'b0;
            moving_ff <= run_ff;
            arrived_ff <= at_target;
            if (!wrap_enable_ff) begin
                acc_ff <= 31'h00000000;
                hold_ff <= 2'h0;
                turns_ff <= `RST_WORD;
            end
            if (reg_wr && reg_addr == `ADDR_ACTUAL_POSITION) begin
                actual_ff <= reg_wdata;
            end else if (reg_wr && reg_addr == `ADDR_TARGET_POSITION) begin
                // a repetitive ramp keeps running when the new nonzero target equals actual
                run_ff <= positioning && ((reg_wdata != actual_ff) ||
                          (zero_on_arrival_ff && (reg_wdata != 32'h00000000)));
            end else if (positioning && at_target) begin
                if (zero_on_arrival_ff) begin
                    actual_ff <= `RST_WORD;
                    run_ff <= (target_ff != 32'h00000000);
                end else begin
                    run_ff <= 1'b0;
                end
            end else if (step_en && positioning && run_ff) begin
                dir_ff <= go_pos;
                if (hold_ff != 2'h0) begin
                    // stay at the wrap point for this step
                    hold_ff <= hold_ff - 2'h1;
                end else if (crossing) begin
                    step_ff <= 1'b1;
                    actual_ff <= hit_top ? bot_pos : top_pos;
                    if (wrap_enable_ff) begin
                        acc_ff <= acc_sum[30:0];
                        hold_ff <= extra_holds;
                        turns_ff <= hit_top ? turns_ff + 32'h00000001
                                            : turns_ff - 32'h00000001;
                    end
                end else begin
                    step_ff <= 1'b1;
                    actual_ff <= go_pos ? actual_ff + 32'h00000001
                                        : actual_ff - 32'h00000001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // the range register is write-only; its address can show turns
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= `RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_GENERAL_CONF: reg_rdata_ff <= {31'h0, turns_at_range_ff};
                `ADDR_REFERENCE_CONFIG_REG: reg_rdata_ff <= {30'h0, wrap_enable_ff,
                                                        zero_on_arrival_ff};
                `ADDR_RAMP_SELECT: reg_rdata_ff <= {29'h0, ramp_select_ff};
                `ADDR_ACTUAL_POSITION: reg_rdata_ff <= actual_ff;
                `ADDR_TARGET_POSITION: reg_rdata_ff <= target_ff;
                `ADDR_CIRCULAR_RANGE: reg_rdata_ff <= turns_at_range_ff ? turns_ff
                                                                        : `RST_WORD;
                `ADDR_REV_FRACTION: reg_rdata_ff <= frac_ff;
                default: reg_rdata_ff <= `RST_WORD;
            endcase
        end
    end

endmodule // circ_pos_core

// ===== test/circ_pos_props.sv
// assertions on the ports of circ_pos_core
// assumes registers change only through reg_wr and the bench never reads and writes at once
`timescale 1ns/100ps
`include "circ_pos_consts.vh"
module circ_pos_props #(
    parameter integer step_cycles = 2
) (
    input wire clk, // core clock
    input wire rst_b, // async reset, active low
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    input wire [6:0] reg_addr, // word address
    input wire [31:0] reg_wdata, // write data
    input wire [31:0] reg_rdata_ff, // read data
    input wire step_ff, // step pulse
    input wire dir_ff, // direction
    input wire moving_ff, // ramp running
    input wire arrived_ff // at target
);
    // ----------------------------------------------------------------
    // shadow of written configuration
    // ----------------------------------------------------------------
    reg [31:0] tgt_ff;
    reg [31:0] frac_ff;
    reg [3:0] cfg_ff; // positioning, turns, wrap, zero_on_arrival
    wire mapped = reg_addr == 7'h00 || reg_addr == 7'h01 || reg_addr == 7'h20 ||
        reg_addr == 7'h21 || reg_addr == 7'h36 || reg_addr == 7'h37 || reg_addr == 7'h7c;
    // follow writes so the assertions know the mode without peeking inside
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tgt_ff <= 32'h0;
            frac_ff <= 32'h0;
            cfg_ff <= 4'h0;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_TARGET_POSITION) tgt_ff <= reg_wdata;
            if (reg_addr == `ADDR_REV_FRACTION) frac_ff <= reg_wdata;
            if (reg_addr == `ADDR_REFERENCE_CONFIG_REG) cfg_ff[1:0] <= reg_wdata[1:0];
            if (reg_addr == `ADDR_GENERAL_CONF) cfg_ff[2] <= reg_wdata[0];
            if (reg_addr == `ADDR_RAMP_SELECT) cfg_ff[3] <= reg_wdata[2];
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_range_reads_zero: assert property (reg_rd && reg_addr == 7'h36 && !(cfg_ff[2] && cfg_ff[1])
        |=> reg_rdata_ff == 32'h0) else $error("range address read not zero");
    a_fraction_read_back: assert property (reg_rd && reg_addr == 7'h7c
        |=> reg_rdata_ff == frac_ff) else $error("fraction read back wrong");
    a_target_read_back: assert property (reg_rd && reg_addr == 7'h37
        |=> reg_rdata_ff == tgt_ff) else $error("target read back wrong");
    a_unmapped_read: assert property (reg_rd && !mapped |=> reg_rdata_ff == 32'h0)
        else $error("unmapped read not zero");
    a_step_one_cycle: assert property (step_ff |=> !step_ff) else $error("step pulse too long");
    a_step_needs_run: assert property (step_ff |-> moving_ff || $past(moving_ff))
        else $error("step without a running ramp");
    a_arrival_stops: assert property ((arrived_ff && !cfg_ff[0] && !reg_wr) [*3]
        |-> !moving_ff) else $error("ramp runs on after arrival");
    a_repeat_keeps_run: assert property (moving_ff && cfg_ff[0] && cfg_ff[3] && tgt_ff != 0
        && !reg_wr |=> moving_ff) else $error("repetitive ramp stopped");
endmodule // circ_pos_props

bind circ_pos_core circ_pos_props #(.step_cycles(step_cycles)) props_u (.clk(clk), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .step_ff(step_ff), .dir_ff(dir_ff), .moving_ff(moving_ff),
    .arrived_ff(arrived_ff));

// ===== test/test_repetitive_circular_position_wrap.sv
// self-checking bench for circ_pos_core
// assumes the checker binds itself; step period shortened to 2 clocks
`timescale 1ns/100ps
`include "circ_pos_consts.vh"
module test_repetitive_circular_position_wrap;
    reg clk, rst_b, reg_wr, reg_rd, first_dir;
    reg [6:0] reg_addr;
    reg [31:0] reg_wdata, rd_val;
    wire [31:0] reg_rdata_ff;
    wire step_ff, dir_ff, moving_ff, arrived_ff;
    integer n_fail = 0, checks = 0, n_step, gap, max_gap, i;
    circ_pos_core #(.step_cycles(2)) dut_u (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
        .step_ff(step_ff), .dir_ff(dir_ff), .moving_ff(moving_ff), .arrived_ff(arrived_ff));
    // 100 MHz core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // access and check tasks
    // ----------------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp); begin
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    end endtask
    task print_verdict; begin
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end endtask
    task wr(input [6:0] a, input [31:0] d); begin
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    end endtask
    // read data lands on the edge that takes the strobe, so sample just after it
    task rd(input [6:0] a); begin
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata_ff;
    end endtask
    // run to a target; widest step gap shows the held steps at the wrap
    task move(input [31:0] t, input [31:0] steps, input [31:0] mgap, input d); begin
        wr(`ADDR_TARGET_POSITION, t);
        n_step = 0;
        max_gap = 0;
        gap = 0;
        for (i = 0; i < 300 && (i < 4 || moving_ff); i = i + 1) begin
            @(posedge clk);
            #1 gap = gap + 1;
            if (step_ff === 1'b1) begin
                if (n_step == 0) first_dir = dir_ff;
                else if (gap > max_gap) max_gap = gap;
                n_step = n_step + 1;
                gap = 0;
            end
        end
        if (i == 300) begin
            n_fail = n_fail + 1;
            print_verdict;
        end
        chk(n_step, steps);
        chk(max_gap, mgap);
        chk({31'h0, first_dir}, {31'h0, d});
        rd(`ADDR_ACTUAL_POSITION);
        chk(rd_val, t);
    end endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h0;
        reg_wdata = 32'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        chk({31'h0, dir_ff}, 32'h1);
        wr(7'h55, 32'hffffffff);
        rd(7'h55);
        chk(rd_val, 32'h0);
        rd(`ADDR_REV_FRACTION);
        chk(rd_val, 32'h0);
        wr(`ADDR_CIRCULAR_RANGE, 32'h4);
        rd(`ADDR_CIRCULAR_RANGE);
        chk(rd_val, 32'h0);
        $display("reset test done");
        wr(`ADDR_RAMP_SELECT, 32'h4);
        move(32'h5, 5, 2, 1'b1);
        repeat (20) @(posedge clk);
        chk({31'h0, moving_ff}, 32'h0);
        $display("single ramp test done");
        // repetitive: actual equals target already, so it clears and restarts
        wr(`ADDR_REFERENCE_CONFIG_REG, 32'h1);
        repeat (60) @(posedge clk);
        chk({31'h0, moving_ff}, 32'h1);
        wr(`ADDR_TARGET_POSITION, 32'h2);
        repeat (40) @(posedge clk);
        rd(`ADDR_ACTUAL_POSITION);
        chk({31'h0, rd_val < 3}, 32'h1);
        wr(`ADDR_TARGET_POSITION, 32'h0);
        repeat (20) @(posedge clk);
        chk({31'h0, moving_ff}, 32'h0);
        rd(`ADDR_ACTUAL_POSITION);
        chk(rd_val, 32'h0);
        wr(`ADDR_REFERENCE_CONFIG_REG, 32'h0);
        $display("repetitive test done");
        // circular range -4..3, turn counter visible at the range address
        wr(`ADDR_GENERAL_CONF, 32'h1);
        wr(`ADDR_REFERENCE_CONFIG_REG, 32'h2);
        move(32'h3, 3, 2, 1'b1);
        move(32'hfffffffd, 2, 2, 1'b1);
        rd(`ADDR_CIRCULAR_RANGE);
        chk(rd_val, 32'h1);
        move(32'h2, 3, 2, 1'b0);
        rd(`ADDR_CIRCULAR_RANGE);
        chk(rd_val, 32'h0);
        wr(`ADDR_REV_FRACTION, 32'ha0000000);
        rd(`ADDR_REV_FRACTION);
        chk(rd_val, 32'ha0000000);
        move(32'hfffffffd, 3, 4, 1'b1);
        move(32'h2, 3, 4, 1'b0);
        move(32'hfffffffd, 3, 4, 1'b1);
        wr(`ADDR_REFERENCE_CONFIG_REG, 32'h0);
        rd(`ADDR_CIRCULAR_RANGE);
        chk(rd_val, 32'h0);
        wr(`ADDR_REFERENCE_CONFIG_REG, 32'h2);
        move(32'h2, 3, 4, 1'b0);
        move(32'hfffffffd, 3, 4, 1'b1);
        move(32'h2, 3, 4, 1'b0);
        move(32'hfffffffd, 3, 6, 1'b1);
        $display("circular test done");
        print_verdict;
    end
endmodule // test_repetitive_circular_position_wrap
